// [hdl/rsd_pkg.sv]
// How it works
// - bits 1:0 pick the current limit source: 00 serial, 01 memory, 10 control port.
// - bits 4:2 pick the diode set point source: 000 serial, 001 memory, 010 port, 100 panel.
// - bits 7:5 pick the cooler temperature set point source with the same four codes.
// - any field of the mode-selected source byte holding a code outside its listed set raises the decoder fault flag.
// - bit 0 of the io control byte of the mode-selected pair (remote or local) approves the port shutdown; bits 7:1 are ignored.
// - each stop byte must equal 0x0B, and both trailing bytes are checked against it.
`default_nettype none
package rsd_pkg;
  // ----------------------------------------------------------------
  // frame byte positions and constants
  // ----------------------------------------------------------------
  localparam logic [7:0] RSD_IDX_LOC_SRC = 8'h13;
  localparam logic [7:0] RSD_IDX_LOC_IOC = 8'h14;
  localparam logic [7:0] RSD_IDX_REM_SRC = 8'h15;
  localparam logic [7:0] RSD_IDX_REM_IOC = 8'h16;
  localparam logic [7:0] RSD_IDX_STOP0 = 8'h17;
  localparam logic [7:0] RSD_IDX_STOP1 = 8'h18;
  localparam logic [7:0] RSD_STOP_BYTE = 8'h0B;
  localparam logic [7:0] RSD_BYTE_RST = 8'h00;
  localparam int RSD_LIM_LSB = 0;
  localparam int RSD_SP_LSB = 2;
  localparam int RSD_TEC_LSB = 5;
  localparam int RSD_SHDN_BIT = 0;

  typedef enum logic [1:0] {
    RSD_LIM_SERIAL = 2'h0,
    RSD_LIM_MEMORY = 2'h1,
    RSD_LIM_CTRLPORT = 2'h2
  } rsd_lim_src_t;

  typedef enum logic [2:0] {
    RSD_SRC_SERIAL = 3'h0,
    RSD_SRC_MEMORY = 3'h1,
    RSD_SRC_CTRLPORT = 3'h2,
    RSD_SRC_PANEL = 3'h4
  } rsd_src_t;

  typedef enum logic [1:0] {
    RSD_ST_DATA = 2'h0,
    RSD_ST_STOP1 = 2'h1,
    RSD_ST_DONE = 2'h2
  } rsd_state_t;

  typedef struct packed {
    logic [1:0] lim_src;
    logic [2:0] sp_src;
    logic [2:0] tec_src;
    logic fault;
    logic shdn_approve;
  } rsd_cfg_t;
endpackage : rsd_pkg
`default_nettype wire

// [hdl/rsd_field_dec.sv]
`default_nettype none
// decodes one source select byte into fields plus a fault bit
module rsd_field_dec (
  input wire logic [7:0] sel_i,
  input wire logic [7:0] ioc_i,
  output rsd_pkg::rsd_cfg_t cfg_o
);
  logic [1:0] lim;
  logic [2:0] sp;
  logic [2:0] tec;
  logic lim_ok;
  logic sp_ok;
  logic tec_ok;

  always_comb
  begin
    lim = sel_i[rsd_pkg::RSD_LIM_LSB +: 2];
    sp = sel_i[rsd_pkg::RSD_SP_LSB +: 3];
    tec = sel_i[rsd_pkg::RSD_TEC_LSB +: 3];
    lim_ok = (lim == rsd_pkg::RSD_LIM_SERIAL) || (lim == rsd_pkg::RSD_LIM_MEMORY)
      || (lim == rsd_pkg::RSD_LIM_CTRLPORT);
    sp_ok = (sp == rsd_pkg::RSD_SRC_SERIAL) || (sp == rsd_pkg::RSD_SRC_MEMORY)
      || (sp == rsd_pkg::RSD_SRC_CTRLPORT) || (sp == rsd_pkg::RSD_SRC_PANEL);
    tec_ok = (tec == rsd_pkg::RSD_SRC_SERIAL) || (tec == rsd_pkg::RSD_SRC_MEMORY)
      || (tec == rsd_pkg::RSD_SRC_CTRLPORT) || (tec == rsd_pkg::RSD_SRC_PANEL);
    cfg_o.lim_src = lim;
    cfg_o.sp_src = sp;
    cfg_o.tec_src = tec;
    cfg_o.fault = ~(lim_ok & sp_ok & tec_ok);
    cfg_o.shdn_approve = ioc_i[rsd_pkg::RSD_SHDN_BIT];
  end
endmodule : rsd_field_dec
`default_nettype wire

// [hdl/rsd_top.sv]
`default_nettype none
module rsd_top (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic byte_valid_i,
  input wire logic [7:0] byte_idx_i,
  input wire logic [7:0] byte_data_i,
  input wire logic remote_mode_i,
  output logic [1:0] lim_src_o,
  output logic [2:0] sp_src_o,
  output logic [2:0] tec_src_o,
  output logic decoder_fault_flag_o,
  output logic remote_shutdown_approve_o,
  output logic frame_done_o,
  output logic stop_error_o
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] rem_src;
    logic [7:0] rem_ioc;
    logic [7:0] loc_src;
    logic [7:0] loc_ioc;
    rsd_pkg::rsd_state_t st;
    rsd_pkg::rsd_cfg_t cfg;
    logic done;
    logic stop_err;
  } rsd_top_state_t;

  rsd_top_state_t s_q;
  rsd_top_state_t s_d;
  logic [7:0] act_src;
  logic [7:0] act_ioc;
  rsd_pkg::rsd_cfg_t dec_cfg;

  // bytes reach the outputs one edge after they are stored, not gated by frame end; mode picks the pair
  assign act_src = remote_mode_i ? s_q.rem_src : s_q.loc_src;
  assign act_ioc = remote_mode_i ? s_q.rem_ioc : s_q.loc_ioc;

  rsd_field_dec u_dec (
    .sel_i(act_src),
    .ioc_i(act_ioc),
    .cfg_o(dec_cfg)
  );

  // ----------------------------------------------------------------
  // frame tracking
  // ----------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    s_d.done = 1'b0;
    s_d.cfg = dec_cfg;
    if (byte_valid_i)
    begin
      case (byte_idx_i)
        rsd_pkg::RSD_IDX_LOC_SRC: s_d.loc_src = byte_data_i;
        rsd_pkg::RSD_IDX_LOC_IOC: s_d.loc_ioc = byte_data_i;
        rsd_pkg::RSD_IDX_REM_SRC: s_d.rem_src = byte_data_i;
        rsd_pkg::RSD_IDX_REM_IOC: s_d.rem_ioc = byte_data_i;
        default: s_d.loc_src = s_d.loc_src;
      endcase
      case (s_q.st)
        rsd_pkg::RSD_ST_DATA,
        rsd_pkg::RSD_ST_DONE:
        begin
          s_d.st = rsd_pkg::RSD_ST_DATA;
          if (byte_idx_i == rsd_pkg::RSD_IDX_STOP0)
          begin
            s_d.st = rsd_pkg::RSD_ST_STOP1;
            s_d.stop_err = (byte_data_i != rsd_pkg::RSD_STOP_BYTE);
          end
        end
        rsd_pkg::RSD_ST_STOP1:
        begin
          // a second stop byte must follow at once
          if (byte_idx_i == rsd_pkg::RSD_IDX_STOP1)
          begin
            s_d.st = rsd_pkg::RSD_ST_DONE;
            s_d.done = 1'b1;
            s_d.stop_err = s_q.stop_err | (byte_data_i != rsd_pkg::RSD_STOP_BYTE);
          end
          else
          begin
            s_d.st = rsd_pkg::RSD_ST_DATA;
            s_d.stop_err = 1'b1;
          end
        end
        default: s_d.st = rsd_pkg::RSD_ST_DATA;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign lim_src_o = s_q.cfg.lim_src;
  assign sp_src_o = s_q.cfg.sp_src;
  assign tec_src_o = s_q.cfg.tec_src;
  assign decoder_fault_flag_o = s_q.cfg.fault;
  assign remote_shutdown_approve_o = s_q.cfg.shdn_approve;
  assign frame_done_o = s_q.done;
  assign stop_error_o = s_q.stop_err;
endmodule : rsd_top
`default_nettype wire

// [tb/rsd_host.sv]
`default_nettype none
module rsd_host (
  input wire logic clk_i,
  output logic valid_o,
  output logic [7:0] idx_o,
  output logic [7:0] data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {valid_o, idx_o, data_o} = 17'h00000;
  task send(input logic [7:0] i, input logic [7:0] d, input logic last);
    @(posedge clk_i);
    valid_o <= 1'b1;
    idx_o <= i;
    data_o <= d;
    if (last)
    begin
      @(posedge clk_i);
      valid_o <= 1'b0;
      // released data must not look like the last byte
      data_o <= ~d;
    end
  endtask : send
  task stop(input logic [7:0] d);
    send(8'h17, d, 1'b0);
    send(8'h18, d, 1'b1);
  endtask : stop
endmodule : rsd_host
`default_nettype wire

// [tb/rsd_monitor.sv]
`default_nettype none
module rsd_monitor (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic byte_valid_i,
  input wire logic [7:0] byte_idx_i,
  input wire logic [7:0] byte_data_i,
  input wire logic remote_mode_i,
  input wire logic [1:0] lim_src_o,
  input wire logic [2:0] sp_src_o,
  input wire logic [2:0] tec_src_o,
  input wire logic decoder_fault_flag_o,
  input wire logic remote_shutdown_approve_o,
  input wire logic frame_done_o,
  input wire logic stop_error_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  sequence s_wr(m, i);
    byte_valid_i && byte_idx_i == i && remote_mode_i == m ##1 remote_mode_i == m;
  endsequence
  sequence s_pair(ok);
    byte_valid_i && byte_idx_i == 8'h17 && (byte_data_i == 8'h0B) == ok
      ##1 byte_valid_i && byte_idx_i == 8'h18 && (byte_data_i == 8'h0B || !ok);
  endsequence
  function automatic logic bad_f(logic [7:0] d);
    return d[1:0] == 2'h3 || !(d[4:2] inside {3'h0, 3'h1, 3'h2, 3'h4})
      || !(d[7:5] inside {3'h0, 3'h1, 3'h2, 3'h4});
  endfunction : bad_f
  a_lim_src: assert property (
    s_wr(1, 8'h15) |=> lim_src_o == $past(byte_data_i[1:0], 2)) else $error("lim");
  a_sp_src: assert property (
    s_wr(1, 8'h15) |=> sp_src_o == $past(byte_data_i[4:2], 2)) else $error("sp");
  a_tec_src: assert property (
    s_wr(1, 8'h15) |=> tec_src_o == $past(byte_data_i[7:5], 2)) else $error("tec");
  a_fault_dec: assert property (
    s_wr(1, 8'h15) |=> decoder_fault_flag_o == bad_f($past(byte_data_i, 2))) else $error("flt");
  a_shdn_bit: assert property (
    s_wr(1, 8'h16) |=> remote_shutdown_approve_o == $past(byte_data_i[0], 2)) else $error("shd");
  a_local_src: assert property (
    s_wr(0, 8'h13) |=> sp_src_o == $past(byte_data_i[4:2], 2)) else $error("loc");
  a_done_pair: assert property (
    s_pair(1) |=> frame_done_o && !stop_error_o) else $error("done");
  a_stop_value: assert property (
    s_pair(0) |=> stop_error_o && frame_done_o) else $error("stop");
endmodule : rsd_monitor
bind rsd_top rsd_monitor mon (.*);
`default_nettype wire

// [tb/tb.sv]
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic remote_mode_i = 1'b1;
  logic byte_valid_i;
  logic [7:0] byte_idx_i, byte_data_i;
  logic [1:0] lim_src_o;
  logic [2:0] sp_src_o, tec_src_o;
  logic decoder_fault_flag_o, remote_shutdown_approve_o, frame_done_o, stop_error_o;
  logic [2:0] c [4] = '{3'h0, 3'h1, 3'h2, 3'h4};
  logic [7:0] bad [4] = '{8'h03, 8'h0C, 8'hE0, 8'h74};
  int mismatches = 0;
  int total_checks = 0;
  rsd_host host (.clk_i(ref_clk_i), .valid_o(byte_valid_i), .idx_o(byte_idx_i),
    .data_o(byte_data_i));
  rsd_top uut (.*);
  initial forever #2 ref_clk_i = ~ref_clk_i;
  task chk(input logic [9:0] v, input logic [9:0] e);
    total_checks++;
    if (v !== e)
    begin
      mismatches++;
      $display("BAD %0t %h %h", $time, v, e);
    end
  endtask : chk
  // shutdown approve is left at 0 by the io test
  task src(input logic [7:0] i, input logic [7:0] b, input logic f);
    host.send(i, b, 1'b1);
    // outputs follow the stored byte one edge later
    @(posedge ref_clk_i);
    #1;
    chk({lim_src_o, sp_src_o, tec_src_o, decoder_fault_flag_o, remote_shutdown_approve_o},
      {b[1:0], b[4:2], b[7:5], f, 1'b0});
  endtask : src
  task print_verdict;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : print_verdict
  initial
  begin
    #8000;
    mismatches++;
    print_verdict();
  end
  initial
  begin
    repeat (4) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    #1;
    chk({lim_src_o, sp_src_o, tec_src_o, decoder_fault_flag_o, frame_done_o}, 10'h000);
    for (int k = 1; k >= 0; k--)
    begin
      host.send(8'h16, {7'h7F, k[0]}, 1'b1);
      @(posedge ref_clk_i);
      #1;
      chk(10'(remote_shutdown_approve_o), 10'(k[0]));
    end
    for (int k = 0; k < 4; k++) src(8'h15, {c[3 - k], c[k], 2'(k % 3)}, 1'b0);
    foreach (bad[k]) src(8'h15, bad[k], 1'b1);
    @(posedge ref_clk_i);
    remote_mode_i <= 1'b0;
    src(8'h13, 8'h46, 1'b0);
    host.send(8'h14, 8'hFF, 1'b1);
    @(posedge ref_clk_i);
    #1;
    chk(10'(remote_shutdown_approve_o), 10'h001);
    @(posedge ref_clk_i);
    remote_mode_i <= 1'b1;
    @(posedge ref_clk_i);
    #1;
    chk({lim_src_o, sp_src_o, tec_src_o, decoder_fault_flag_o, remote_shutdown_approve_o},
      10'h0AE);
    host.stop(8'h0B);
    #1;
    chk({frame_done_o, stop_error_o}, 10'h002);
    host.stop(8'h0A);
    #1;
    chk({frame_done_o, stop_error_o}, 10'h003);
    host.send(8'h17, 8'h0B, 1'b1);
    host.send(8'h15, 8'h00, 1'b1);
    host.send(8'h18, 8'h0B, 1'b1);
    #1;
    chk({frame_done_o, stop_error_o}, 10'h001);
    print_verdict();
  end
endmodule : tb
`default_nettype wire
